/* pkg/csr_pkg.sv */
// Purpose: constants for the core system control register bank
// Assumes: 64-bit register port, word index addressing
// Notes: register indices are local to this bank
package csr_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 64;

   // register indices
   localparam logic [3:0] IDX_AFFINITY = 4'h0;
   localparam logic [3:0] IDX_EXT_AFF_LOW = 4'h1;
   localparam logic [3:0] IDX_EXT_AFF_HIGH = 4'h2;
   localparam logic [3:0] IDX_XLAT_RESULT = 4'h3;
   localparam logic [3:0] IDX_REVISION = 4'h4;
   localparam logic [3:0] IDX_RESET_MGMT = 4'h5;
   localparam logic [3:0] IDX_RESET_VECTOR = 4'h6;
   localparam logic [3:0] IDX_SYSCTL_L1 = 4'h7;
   localparam logic [3:0] IDX_SYSCTL_L2 = 4'h8;
   localparam logic [3:0] IDX_SYSCTL_L3 = 4'h9;
   localparam logic [3:0] IDX_XLAT_CTL_L1 = 4'ha;

   // affinity layout
   localparam int unsigned AFF_CORE_LSB = 8;
   localparam int unsigned AFF_CORE_W = 3;
   localparam logic [63:0] AFF_FIXED_ONES = 64'h0000_0000_8000_0000;

   // translation result layout
   localparam int unsigned XR_ABORT_BIT = 0;
   localparam int unsigned XR_RSVD_BIT = 10;

   // reset management layout
   localparam int unsigned RM_REQ_BIT = 1;
   localparam logic [63:0] RM_FIXED_ONES = 64'h0000_0000_0000_0001;

   // reset vector legal bits: [39:2]
   localparam logic [63:0] RV_LEGAL_MASK = 64'h0000_00ff_ffff_fffc;

   // system control layouts
   localparam int unsigned SC_DEFAULT_STORE_BYPASS_SAFE_BIT = 44;
   localparam int unsigned SC_EE_BIT = 25;
   localparam int unsigned SC_ICACHE_BIT = 12;
   localparam int unsigned SC_BARRIER_BIT = 5;
   localparam int unsigned SC_DCACHE_BIT = 2;
   localparam int unsigned SC_MMU_BIT = 0;
   localparam logic [63:0] SC_L1_RESET = 64'h0000_0000_30d5_0838;
   localparam logic [63:0] SC_L23_RESET = 64'h0000_0000_30c5_0838;
   localparam logic [63:0] SC_FIXED_ONES = 64'h0000_0000_3000_0000;
   localparam logic [63:0] SC_L1_WR_MASK = 64'h0000_1000_07ff_ff3f;
   localparam logic [63:0] SC_L23_WR_MASK = 64'h0000_1000_03ff_ffff;

   // translation control layout
   localparam int unsigned TC_HA_BIT = 39;
   localparam int unsigned TC_HD_BIT = 40;
   localparam logic [63:0] TC_RESET = 64'h0000_0000_0000_0000;

   // exception target levels
   localparam logic [1:0] LVL_ONE = 2'h1;
   localparam logic [1:0] LVL_TWO = 2'h2;
   localparam logic [1:0] LVL_THREE = 2'h3;
endpackage : csr_pkg

/* core/csr_bank.sv */
// Purpose: core system control register bank behind a plain register port
// Assumes: single 125 MHz clock, synchronous active-low reset for warm and cold
// Notes: read data valid one cycle after the read strobe, zero when unmapped
`timescale 1ns/100ps
module csr_bank #(
   parameter logic [31:0] REVISION_DETAIL = 32'h0000_0000, // arbitrary value
   parameter logic [63:0] BOOT_VECTOR = 64'h0000_0000_0000_0000,
   parameter bit LEVEL_TWO_PRESENT = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [csr_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [csr_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [csr_pkg::DATA_W-1:0] reg_rdata,
   // configuration pins
   input wire logic [csr_pkg::AFF_CORE_W-1:0] core_index,
   input wire logic boot_endian_strap,
   // address translation completion
   input wire logic xlat_done,
   input wire logic xlat_abort,
   input wire logic [63:1] xlat_payload,
   // exception entry
   input wire logic exc_taken,
   input wire logic [1:0] exc_target_level,
   // processor state and controls
   output logic store_bypass_safe_state,
   output logic warm_reset_request,
   output logic level1_mmu_enable,
   output logic level1_big_endian,
   output logic legacy_barrier_undefined,
   output logic level3_big_endian,
   output logic level3_icache_enable,
   output logic level3_dcache_enable,
   output logic level3_mmu_enable,
   output logic access_flag_hw_update,
   output logic dirty_state_hw_update
);

   function automatic logic hit(input logic [csr_pkg::ADDR_W-1:0] a,
                                input logic [3:0] idx);
      hit = (a == idx);
   endfunction : hit

   // write merge: writable bits from software, fixed ones forced high
   function automatic logic [63:0] merge(input logic [63:0] wd,
                                         input logic [63:0] wmask,
                                         input logic [63:0] ones);
      merge = (wd & wmask) | ones;
   endfunction : merge

   // 32-bit views sit in the low half, upper half reads zero
   function automatic logic [63:0] widen(input logic [31:0] w);
      widen = {32'h0000_0000, w};
   endfunction : widen

   // pin synchronisers
   logic [csr_pkg::AFF_CORE_W-1:0] core_index_meta_q;
   logic [csr_pkg::AFF_CORE_W-1:0] core_index_q;
   logic strap_meta_q;
   logic strap_q;

   always_ff @(posedge clk)
   begin
      core_index_meta_q <= core_index;
      core_index_q <= core_index_meta_q;
      strap_meta_q <= boot_endian_strap;
      strap_q <= strap_meta_q;
   end

   // register storage
   logic [63:0] xlat_result_q;
   logic rm_req_q;
   logic [63:0] sysctl_l1_q;
   logic [63:0] sysctl_l2_q;
   logic [63:0] sysctl_l3_q;
   logic [63:0] xlat_ctl_l1_q;
   logic store_bypass_safe_state_q;
   logic [63:0] rdata_q;

   logic wr_xr;
   logic wr_rm;
   logic wr_l1;
   logic wr_l2;
   logic wr_l3;
   logic wr_tc;

   assign wr_xr = reg_wr && hit(reg_addr, csr_pkg::IDX_XLAT_RESULT);
   assign wr_rm = reg_wr && hit(reg_addr, csr_pkg::IDX_RESET_MGMT);
   assign wr_l1 = reg_wr && hit(reg_addr, csr_pkg::IDX_SYSCTL_L1);
   assign wr_l2 = reg_wr && hit(reg_addr, csr_pkg::IDX_SYSCTL_L2)
                  && LEVEL_TWO_PRESENT;
   assign wr_l3 = reg_wr && hit(reg_addr, csr_pkg::IDX_SYSCTL_L3);
   assign wr_tc = reg_wr && hit(reg_addr, csr_pkg::IDX_XLAT_CTL_L1);

   // affinity value
   logic [63:0] affinity;

   always_comb
   begin
      affinity = csr_pkg::AFF_FIXED_ONES;
      affinity[csr_pkg::AFF_CORE_LSB +: csr_pkg::AFF_CORE_W] = core_index_q;
      // bits 7:0 left at zero, single thread per core
      affinity[csr_pkg::AFF_CORE_LSB-1:0] = '0;
   end

   // translation result; hardware completion wins over a same-cycle write
   logic [63:0] xlat_fill;

   always_comb
   begin
      xlat_fill = {xlat_payload, 1'b0};
      if (xlat_abort)
      begin
         xlat_fill[csr_pkg::XR_ABORT_BIT] = 1'b1;
      end
      else
      begin
         xlat_fill[csr_pkg::XR_RSVD_BIT] = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         xlat_result_q <= '0;
      end
      else if (xlat_done)
      begin
         xlat_result_q <= xlat_fill;
      end
      else if (wr_xr)
      begin
         xlat_result_q <= reg_wdata;
         if (!reg_wdata[csr_pkg::XR_ABORT_BIT])
         begin
            xlat_result_q[csr_pkg::XR_RSVD_BIT] <= 1'b0;
         end
      end
   end

   // reset management: the request is only a level to the reset controller
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rm_req_q <= 1'b0;
      end
      else if (wr_rm)
      begin
         rm_req_q <= reg_wdata[csr_pkg::RM_REQ_BIT];
      end
   end

   // level one system control
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sysctl_l1_q <= csr_pkg::SC_L1_RESET;
      end
      else if (wr_l1)
      begin
         // mask keeps bit 7 and reserved bits fixed
         sysctl_l1_q <= merge(reg_wdata, csr_pkg::SC_L1_WR_MASK,
                              csr_pkg::SC_FIXED_ONES);
      end
   end

   // level two system control; bit 44 position independent of mode bits
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sysctl_l2_q <= csr_pkg::SC_L23_RESET;
      end
      else if (wr_l2)
      begin
         sysctl_l2_q <= merge(reg_wdata, csr_pkg::SC_L23_WR_MASK,
                              csr_pkg::SC_FIXED_ONES);
      end
   end

   // level three system control; endianness taken from the strap at reset
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sysctl_l3_q <= csr_pkg::SC_L23_RESET;
         sysctl_l3_q[csr_pkg::SC_EE_BIT] <= strap_q;
      end
      else if (wr_l3)
      begin
         sysctl_l3_q <= merge(reg_wdata, csr_pkg::SC_L23_WR_MASK,
                              csr_pkg::SC_FIXED_ONES);
      end
   end

   // translation control: zero reset stands in for unknown
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         xlat_ctl_l1_q <= csr_pkg::TC_RESET;
      end
      else if (wr_tc)
      begin
         xlat_ctl_l1_q <= reg_wdata;
      end
   end

   // store-bypass state loaded from the target level on exception entry
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         store_bypass_safe_state_q <= 1'b0;
      end
      else if (exc_taken)
      begin
         case (exc_target_level)
            csr_pkg::LVL_ONE:
               store_bypass_safe_state_q <= sysctl_l1_q[csr_pkg::SC_DEFAULT_STORE_BYPASS_SAFE_BIT];
            csr_pkg::LVL_TWO:
            begin
               if (LEVEL_TWO_PRESENT)
               begin
                  store_bypass_safe_state_q <= sysctl_l2_q[csr_pkg::SC_DEFAULT_STORE_BYPASS_SAFE_BIT];
               end
            end
            csr_pkg::LVL_THREE:
               store_bypass_safe_state_q <= sysctl_l3_q[csr_pkg::SC_DEFAULT_STORE_BYPASS_SAFE_BIT];
            default:
               store_bypass_safe_state_q <= store_bypass_safe_state_q;
         endcase
      end
   end

   // level one controls, one edge behind the register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         level1_mmu_enable <= 1'b0;
         level1_big_endian <= 1'b0;
         legacy_barrier_undefined <= 1'b0;
      end
      else
      begin
         level1_mmu_enable <= sysctl_l1_q[csr_pkg::SC_MMU_BIT];
         level1_big_endian <= sysctl_l1_q[csr_pkg::SC_EE_BIT];
         legacy_barrier_undefined <= !sysctl_l1_q[csr_pkg::SC_BARRIER_BIT];
      end
   end

   // level three controls
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         level3_big_endian <= 1'b0;
         level3_icache_enable <= 1'b0;
         level3_dcache_enable <= 1'b0;
         level3_mmu_enable <= 1'b0;
      end
      else
      begin
         level3_big_endian <= sysctl_l3_q[csr_pkg::SC_EE_BIT];
         level3_icache_enable <= sysctl_l3_q[csr_pkg::SC_ICACHE_BIT];
         level3_dcache_enable <= sysctl_l3_q[csr_pkg::SC_DCACHE_BIT];
         level3_mmu_enable <= sysctl_l3_q[csr_pkg::SC_MMU_BIT];
      end
   end

   // hardware table update enables
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         access_flag_hw_update <= 1'b0;
         dirty_state_hw_update <= 1'b0;
      end
      else
      begin
         access_flag_hw_update <= xlat_ctl_l1_q[csr_pkg::TC_HA_BIT];
         // dirty tracking is meaningless without access flag tracking
         dirty_state_hw_update <= xlat_ctl_l1_q[csr_pkg::TC_HD_BIT]
                                  && xlat_ctl_l1_q[csr_pkg::TC_HA_BIT];
      end
   end

   // read multiplexer
   logic [63:0] rd_value;

   always_comb
   begin
      rd_value = '0;
      case (reg_addr)
         csr_pkg::IDX_AFFINITY:
            rd_value = affinity;
         csr_pkg::IDX_EXT_AFF_LOW:
            rd_value = widen(affinity[31:0]);
         csr_pkg::IDX_EXT_AFF_HIGH:
            rd_value = widen(affinity[63:32]);
         csr_pkg::IDX_XLAT_RESULT:
            rd_value = xlat_result_q;
         csr_pkg::IDX_REVISION:
            rd_value = widen(REVISION_DETAIL);
         csr_pkg::IDX_RESET_MGMT:
         begin
            rd_value = csr_pkg::RM_FIXED_ONES;
            rd_value[csr_pkg::RM_REQ_BIT] = rm_req_q;
         end
         csr_pkg::IDX_RESET_VECTOR:
            rd_value = BOOT_VECTOR & csr_pkg::RV_LEGAL_MASK;
         csr_pkg::IDX_SYSCTL_L1:
            rd_value = sysctl_l1_q;
         csr_pkg::IDX_SYSCTL_L2:
            rd_value = LEVEL_TWO_PRESENT ? sysctl_l2_q : '0;
         csr_pkg::IDX_SYSCTL_L3:
            rd_value = sysctl_l3_q;
         csr_pkg::IDX_XLAT_CTL_L1:
            rd_value = xlat_ctl_l1_q;
         default:
            rd_value = '0;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rdata_q <= '0;
      end
      else if (reg_rd)
      begin
         rdata_q <= rd_value;
      end
      else
      begin
         rdata_q <= '0;
      end
   end

   assign reg_rdata = rdata_q;
   assign store_bypass_safe_state = store_bypass_safe_state_q;
   assign warm_reset_request = rm_req_q;

endmodule : csr_bank

/* tb/csr_bank_monitor.sv */
// Purpose: port checker for the system control register bank
// Assumes: controls follow a register write two edges later
// Notes: attached by bind, watches the register port, core index pin, exception inputs and design outputs except access_flag_hw_update
`timescale 1ns/100ps
module csr_bank_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [63:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [63:0] reg_rdata,
   // pins and events
   input wire logic [2:0] core_index,
   input wire logic exc_taken,
   input wire logic [1:0] exc_target_level,
   // controls
   input wire logic store_bypass_safe_state,
   input wire logic warm_reset_request,
   input wire logic level1_mmu_enable,
   input wire logic level1_big_endian,
   input wire logic legacy_barrier_undefined,
   input wire logic level3_big_endian,
   input wire logic level3_icache_enable,
   input wire logic level3_dcache_enable,
   input wire logic level3_mmu_enable,
   input wire logic dirty_state_hw_update
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_wr(logic [3:0] idx);
      reg_wr && reg_addr == idx;
   endsequence
   // read data answers the strobe of the edge before
   sequence s_rd(logic [3:0] idx);
      $past(reg_rd && reg_addr == idx);
   endsequence

   chk_affinity_fields: assert property (
      s_rd(csr_pkg::IDX_AFFINITY) |-> reg_rdata[7:0] == 8'h00 && reg_rdata[10:8] == core_index)
      else $error("affinity fields wrong");
   chk_vector_align: assert property (
      s_rd(csr_pkg::IDX_RESET_VECTOR) |-> reg_rdata[1:0] == 2'h0 && reg_rdata[63:40] == 24'h0)
      else $error("reset vector bits outside 39:2");
   chk_rmgmt_layout: assert property (
      s_rd(csr_pkg::IDX_RESET_MGMT) |-> reg_rdata[63:2] == 62'h0 && reg_rdata[0])
      else $error("reset management layout wrong");
   chk_rev_upper: assert property (
      s_rd(csr_pkg::IDX_REVISION) |-> reg_rdata[63:32] == 32'h0)
      else $error("revision upper word not zero");
   chk_req_follow: assert property (
      s_wr(csr_pkg::IDX_RESET_MGMT) |-> ##2 warm_reset_request == $past(reg_wdata[1], 2))
      else $error("warm reset request does not follow write");
   chk_l1_controls: assert property (
      s_wr(csr_pkg::IDX_SYSCTL_L1) |-> ##2 level1_mmu_enable == $past(reg_wdata[0], 2)
         && level1_big_endian == $past(reg_wdata[25], 2)
         && legacy_barrier_undefined == !$past(reg_wdata[5], 2))
      else $error("level one controls wrong");
   chk_l3_controls: assert property (
      s_wr(csr_pkg::IDX_SYSCTL_L3) |-> ##2 level3_mmu_enable == $past(reg_wdata[0], 2)
         && level3_dcache_enable == $past(reg_wdata[2], 2)
         && level3_icache_enable == $past(reg_wdata[12], 2)
         && level3_big_endian == $past(reg_wdata[25], 2))
      else $error("level three controls wrong");
   chk_dirty_gate: assert property (
      s_wr(csr_pkg::IDX_XLAT_CTL_L1) |-> ##2
         dirty_state_hw_update == ($past(reg_wdata[40], 2) && $past(reg_wdata[39], 2)))
      else $error("dirty update not gated by access flag");
   chk_bypass_hold: assert property (
      (!exc_taken || exc_target_level == 2'h0) |=> $stable(store_bypass_safe_state))
      else $error("store bypass state moved without entry");
endmodule : csr_bank_monitor

bind csr_bank csr_bank_monitor u_mon (
   .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_index,
   .exc_taken, .exc_target_level, .store_bypass_safe_state, .warm_reset_request,
   .level1_mmu_enable, .level1_big_endian, .legacy_barrier_undefined, .level3_big_endian,
   .level3_icache_enable, .level3_dcache_enable, .level3_mmu_enable, .dirty_state_hw_update
);

/* tb/csr_bank_tb_top.sv */
// Purpose: directed bench for the system control register bank
// Assumes: strap high, core pin 5; a second bank has level two absent
// Notes: data sampled mid-cycle to stay clear of edge races
`timescale 1ns/100ps
module csr_bank_tb_top;
   logic clk;
   logic rst_n;
   logic [3:0] reg_addr;
   logic [63:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [63:0] reg_rdata;
   logic [2:0] core_index;
   logic boot_endian_strap;
   logic xlat_done;
   logic xlat_abort;
   logic [63:1] xlat_payload;
   logic exc_taken;
   logic [1:0] exc_target_level;
   // bypass, request, l1 mmu/be/undef, l3 be/i/d/mmu, flag, dirty
   wire [10:0] outs;
   wire [63:0] rdata_nol2;
   wire store_bypass_safe_state_nol2;
   int err_count;
   int check_count;

   csr_bank #(.REVISION_DETAIL(32'h5a5a_5a5a), .BOOT_VECTOR(64'hffff_ffff_ffff_ffff),
      .LEVEL_TWO_PRESENT(1'b1)) DUT (
      .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_index,
      .boot_endian_strap, .xlat_done, .xlat_abort, .xlat_payload, .exc_taken,
      .exc_target_level, .store_bypass_safe_state(outs[10]), .warm_reset_request(outs[9]),
      .level1_mmu_enable(outs[8]), .level1_big_endian(outs[7]),
      .legacy_barrier_undefined(outs[6]), .level3_big_endian(outs[5]),
      .level3_icache_enable(outs[4]), .level3_dcache_enable(outs[3]),
      .level3_mmu_enable(outs[2]), .access_flag_hw_update(outs[1]),
      .dirty_state_hw_update(outs[0]));

   // shares every input with the main bank, only the absent-level behaviour is judged
   csr_bank #(.LEVEL_TWO_PRESENT(1'b0)) dut_no_level2 (
      .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata_nol2),
      .core_index, .boot_endian_strap, .xlat_done, .xlat_abort, .xlat_payload, .exc_taken,
      .exc_target_level, .store_bypass_safe_state(store_bypass_safe_state_nol2), .warm_reset_request(),
      .level1_mmu_enable(), .level1_big_endian(), .legacy_barrier_undefined(),
      .level3_big_endian(), .level3_icache_enable(), .level3_dcache_enable(),
      .level3_mmu_enable(), .access_flag_hw_update(), .dirty_state_hw_update());

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic drv(input logic w, input logic r, input logic [3:0] a, input logic [63:0] d);
      @(posedge clk);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
   endtask : drv

   task automatic wr(input logic [3:0] a, input logic [63:0] d);
      drv(1'b1, 1'b0, a, d);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [63:0] exp);
      drv(1'b0, 1'b1, a, 64'h0);
      drv(1'b0, 1'b0, a, 64'h0);
      @(negedge clk);
      chk(reg_rdata, exp);
   endtask : rd

   // controls lag the register by one edge, so wait one more
   task automatic idle1;
      drv(1'b0, 1'b0, 4'h0, 64'h0);
      @(posedge clk);
      @(negedge clk);
   endtask : idle1

   task automatic xfer(input logic ab, input logic [63:1] p, input logic w);
      @(posedge clk);
      xlat_done <= 1'b1;
      xlat_abort <= ab;
      xlat_payload <= p;
      reg_wr <= w;
      reg_addr <= csr_pkg::IDX_XLAT_RESULT;
      reg_wdata <= 64'hffff_ffff_ffff_ffff;
      @(posedge clk);
      xlat_done <= 1'b0;
      reg_wr <= 1'b0;
   endtask : xfer

   task automatic exc(input logic [1:0] l, input logic e);
      @(posedge clk);
      exc_taken <= 1'b1;
      exc_target_level <= l;
      @(posedge clk);
      exc_taken <= 1'b0;
      @(negedge clk);
      chk(64'(outs[10]), 64'(e));
   endtask : exc

   task automatic tc(input logic [63:0] d, input logic [1:0] e);
      wr(csr_pkg::IDX_XLAT_CTL_L1, d);
      idle1;
      chk(64'(outs[1:0]), 64'(e));
   endtask : tc

   task automatic t_reset_vals;
      idle1;
      chk(64'(outs), 64'h0020);
      rd(csr_pkg::IDX_SYSCTL_L1, 64'h0000_0000_30d5_0838);
      rd(csr_pkg::IDX_SYSCTL_L2, 64'h0000_0000_30c5_0838);
      rd(csr_pkg::IDX_SYSCTL_L3, 64'h0000_0000_32c5_0838);
      rd(csr_pkg::IDX_RESET_MGMT, 64'h1);
      rd(csr_pkg::IDX_XLAT_CTL_L1, 64'h0);
      $display("test reset_vals done");
   endtask : t_reset_vals

   task automatic t_ids;
      wr(csr_pkg::IDX_AFFINITY, 64'hffff_ffff_ffff_ffff);
      wr(csr_pkg::IDX_REVISION, 64'hffff_ffff_ffff_ffff);
      wr(csr_pkg::IDX_RESET_VECTOR, 64'hffff_ffff_ffff_ffff);
      wr(4'hf, 64'hffff_ffff_ffff_ffff);
      rd(csr_pkg::IDX_AFFINITY, 64'h8000_0500);
      rd(csr_pkg::IDX_EXT_AFF_LOW, 64'h8000_0500);
      rd(csr_pkg::IDX_EXT_AFF_HIGH, 64'h0);
      rd(csr_pkg::IDX_REVISION, 64'h5a5a_5a5a);
      rd(csr_pkg::IDX_RESET_VECTOR, 64'h0000_00ff_ffff_fffc);
      for (int i = 11; i < 16; i++)
      begin
         rd(4'(i), 64'h0);
      end
      $display("test ids done");
   endtask : t_ids

   task automatic t_sysctl;
      wr(csr_pkg::IDX_SYSCTL_L1, 64'hffff_ffff_ffff_ffff);
      idle1;
      chk(64'(outs), 64'h01a0);
      rd(csr_pkg::IDX_SYSCTL_L1, 64'h0000_1000_37ff_ff3f);
      wr(csr_pkg::IDX_SYSCTL_L1, 64'h0000_1000_0000_0000);
      wr(csr_pkg::IDX_SYSCTL_L3, 64'hffff_ffff_ffff_ffff);
      idle1;
      chk(64'(outs), 64'h007c);
      rd(csr_pkg::IDX_SYSCTL_L3, 64'h0000_1000_33ff_ffff);
      wr(csr_pkg::IDX_SYSCTL_L2, 64'h0);
      rd(csr_pkg::IDX_SYSCTL_L2, 64'h3000_0000);
      chk(rdata_nol2, 64'h0);
      exc(2'h1, 1'b1);
      exc(2'h0, 1'b1);
      exc(2'h2, 1'b0);
      chk(64'(store_bypass_safe_state_nol2), 64'h1);
      exc(2'h3, 1'b1);
      $display("test sysctl done");
   endtask : t_sysctl

   task automatic t_xlat;
      xfer(1'b0, 63'h7fff_ffff_ffff_ffff, 1'b0);
      rd(csr_pkg::IDX_XLAT_RESULT, 64'hffff_ffff_ffff_fbfe);
      xfer(1'b1, 63'h0200, 1'b0);
      rd(csr_pkg::IDX_XLAT_RESULT, 64'h0401);
      xfer(1'b0, 63'h0001, 1'b1);
      rd(csr_pkg::IDX_XLAT_RESULT, 64'h0002);
      wr(csr_pkg::IDX_XLAT_RESULT, 64'hffff_ffff_ffff_fffe);
      rd(csr_pkg::IDX_XLAT_RESULT, 64'hffff_ffff_ffff_fbfe);
      tc(64'h0000_0100_0000_0000, 2'h0);
      tc(64'h0000_0080_0000_0000, 2'h2);
      tc(64'h0000_0180_0000_0000, 2'h3);
      rd(csr_pkg::IDX_XLAT_CTL_L1, 64'h0000_0180_0000_0000);
      $display("test xlat done");
   endtask : t_xlat

   task automatic t_rmr;
      wr(csr_pkg::IDX_RESET_MGMT, 64'hffff_ffff_ffff_ffff);
      idle1;
      chk(64'(outs[9]), 64'h1);
      rd(csr_pkg::IDX_RESET_MGMT, 64'h3);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_vals;
      $display("test rmr done");
   endtask : t_rmr

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial
   begin
      repeat (3000) @(posedge clk);
      err_count++;
      report_and_stop;
   end

   initial
   begin
      err_count = 0;
      check_count = 0;
      rst_n = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 64'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      core_index = 3'h5;
      boot_endian_strap = 1'b1;
      xlat_done = 1'b0;
      xlat_abort = 1'b0;
      xlat_payload = 63'h0;
      exc_taken = 1'b0;
      exc_target_level = 2'h0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_vals;
      t_ids;
      t_sysctl;
      t_xlat;
      t_rmr;
      report_and_stop;
   end
endmodule : csr_bank_tb_top
